// ===== hw/watchdog_cause_flag_count.sv
`timescale 1ns/1ps
// Timeout counter in oscillator ticks with selectable period
module watchdog_cause_flag_count
   import watchdog_cause_flag_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Control from the register block
   watchdog_cause_flag_cnt_if.counter   cif
);

   typedef struct packed {
      logic [CNT_BITS-1:0] cnt;
      logic                timeout;
   } watchdog_cause_flag_count_s;

   watchdog_cause_flag_count_s         s;
   watchdog_cause_flag_count_s         next_s;
   logic [3:0]          code;
   logic [CNT_BITS-1:0] limit;

   // Reserved codes fall back to the longest period
   always_comb begin
      code  = (cif.period > PER_MAX) ? PER_MAX : cif.period;
      limit = CNT_BITS'((32'h1 << (PER_BASE_LOG2 + int'(code))) - 32'h1);
   end

   // Compare with >= so a switch to a shorter period fires on the next tick
   always_comb begin
      next_s = s;
      next_s.timeout = 1'b0;
      if (cif.restart || !cif.run) begin
         next_s.cnt = '0;
      end else if (cif.tick) begin
         if (s.cnt >= limit) begin
            next_s.cnt     = '0;
            next_s.timeout = 1'b1;
         end else begin
            next_s.cnt = s.cnt + CNT_BITS'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cif.timeout = s.timeout;

   property p_restart_clears;
      @(posedge ref_clk) disable iff (!resetn)
      cif.restart |=> (s.cnt == '0) && !s.timeout;
   endproperty
   a_restart_clears: assert property (p_restart_clears) else $error("counter not cleared by restart");

   property p_period_len;
      @(posedge ref_clk) disable iff (!resetn)
      (cif.run && !cif.restart && cif.tick && s.cnt < limit) |=> !s.timeout;
   endproperty
   a_period_len: assert property (p_period_len) else $error("timeout before period end");

endmodule // watchdog_cause_flag_count

// ===== hw/watchdog_cause_flag_tick.sv
`timescale 1ns/1ps
// Stands in for the separate slow oscillator: one enable pulse per tick
module watchdog_cause_flag_tick
   import watchdog_cause_flag_pkg::*;
#(
   parameter int unsigned DIV = OSC_DIV
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Tick output
   watchdog_cause_flag_cnt_if.tick_src  osc
);

   typedef struct packed {
      logic [DIV_BITS-1:0] cnt;
      logic                tick;
   } watchdog_cause_flag_tick_s;

   watchdog_cause_flag_tick_s s;
   watchdog_cause_flag_tick_s next_s;

   // Free-running divider, never gated, so the period keeps its phase
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == DIV_BITS'(DIV - 1)) begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + DIV_BITS'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign osc.tick = s.tick;

endmodule // watchdog_cause_flag_tick

// ===== hw/watchdog_cause_flag_top.sv
`timescale 1ns/1ps
// Watchdog with reset-cause flags, reached through the core I/O space
module watchdog_cause_flag_top
   import watchdog_cause_flag_pkg::*;
#(
   parameter int unsigned OSC_DIVIDE = OSC_DIV
) (
   // Clock and power-on reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Core I/O register port
   input  wire logic [7:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   // Core events
   input  wire logic       wdr_exec,
   input  wire logic       vector_ack,
   input  wire logic       global_irq_enable,
   output logic            irq_req,
   // Reset system
   input  wire logic       always_on_fuse,
   input  wire logic       ext_reset_event,
   input  wire logic       bor_reset_event,
   output logic            sys_reset_pulse
);

   typedef struct packed {
      logic                timeout_irq_flag;
      logic                timeout_irq_enable;
      logic                reset_enable_bit;
      logic [2:0]          ce_cnt;
      logic [PER_BITS-1:0] period_select;
      logic                watchdog_cause_flag;
      logic                brownout_cause_flag;
      logic                external_cause_flag;
      logic                poweron_cause_flag;
      logic                sys_rst;
      logic [7:0]          rdata;
   } watchdog_cause_flag_top_s;

   watchdog_cause_flag_top_s  s;
   watchdog_cause_flag_top_s  next_s;
   watchdog_cause_flag_mode_e mode;
   logic       fuse_prog;
   logic       wde_eff;
   logic       ie_eff;
   logic       change_enable_bit;
   logic       wr_ctl;
   logic       wr_cause;
   logic       ce_open;
   logic       to_irq;
   logic       to_rst;
   logic       sys_reinit;
   logic [7:0] ctl_view;
   logic [7:0] cause_view;

   watchdog_cause_flag_cnt_if cif ();

   // Oscillator tick source
   watchdog_cause_flag_tick #(
      .DIV (OSC_DIVIDE)
   ) u_tick (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .osc     (cif.tick_src)
   );

   // Timeout counter
   watchdog_cause_flag_count u_count (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .cif     (cif.counter)
   );

   // Effective enables; fuse and cause flag override the stored bits
   always_comb begin
      fuse_prog         = !always_on_fuse;
      wde_eff           = s.reset_enable_bit | s.watchdog_cause_flag | fuse_prog;
      ie_eff            = s.timeout_irq_enable & !fuse_prog;
      change_enable_bit = (s.ce_cnt != 3'h0);
   end

   // Mode selection from the two enables
   always_comb begin
      case ({wde_eff, ie_eff})
         2'b00:   mode = WATCHDOG_CAUSE_FLAG_STOP;
         2'b01:   mode = WATCHDOG_CAUSE_FLAG_IRQ;
         2'b10:   mode = WATCHDOG_CAUSE_FLAG_RST;
         default: mode = WATCHDOG_CAUSE_FLAG_BOTH;
      endcase
   end

   // Address decode of the two registers
   always_comb begin
      wr_ctl   = 1'b0;
      wr_cause = 1'b0;
      if (io_wr && io_addr == ADDR_WDCTL) begin
         wr_ctl = 1'b1;
      end else if (io_wr && io_addr == ADDR_CAUSE) begin
         wr_cause = 1'b1;
      end
   end

   // Opening write sets change and reset enables together
   assign ce_open = wr_ctl && io_wdata[CTL_CE] && io_wdata[CTL_WDE];

   // Timeout action per mode; combined mode escalates if flag unserviced
   always_comb begin
      to_irq = 1'b0;
      to_rst = 1'b0;
      case (mode)
         WATCHDOG_CAUSE_FLAG_IRQ: begin
            to_irq = cif.timeout;
         end
         WATCHDOG_CAUSE_FLAG_RST: begin
            to_rst = cif.timeout;
         end
         WATCHDOG_CAUSE_FLAG_BOTH: begin
            to_irq = cif.timeout && !s.timeout_irq_flag;
            to_rst = cif.timeout && s.timeout_irq_flag;
         end
         default: begin
            to_irq = 1'b0;
         end
      endcase
   end

   // Any system reset puts the watchdog set-up back to its reset state
   assign sys_reinit = to_rst || ext_reset_event || bor_reset_event;

   // Read views; period select split over bit 5 and bits 2:0
   always_comb begin
      ctl_view                         = 8'h00;
      ctl_view[CTL_IF]                 = s.timeout_irq_flag;
      ctl_view[CTL_IE]                 = ie_eff;
      ctl_view[CTL_P3]                 = s.period_select[3];
      ctl_view[CTL_CE]                 = change_enable_bit;
      ctl_view[CTL_WDE]                = wde_eff;
      ctl_view[CTL_PLO+2:CTL_PLO]      = s.period_select[2:0];
      cause_view                       = 8'h00;
      cause_view[CAUSE_WD]             = s.watchdog_cause_flag;
      cause_view[CAUSE_BO]             = s.brownout_cause_flag;
      cause_view[CAUSE_EXT]            = s.external_cause_flag;
      cause_view[CAUSE_PO]             = s.poweron_cause_flag;
   end

   // Register state update; hardware sets are applied last so they win
   always_comb begin
      next_s         = s;
      next_s.sys_rst = to_rst;
      // Change window counts down on its own
      if (change_enable_bit) begin
         next_s.ce_cnt = s.ce_cnt - 3'h1;
      end
      // Control register write
      if (wr_ctl) begin
         next_s.timeout_irq_enable = io_wdata[CTL_IE];
         // Reset enable may always be set, cleared only inside the window
         next_s.reset_enable_bit = io_wdata[CTL_WDE] | (s.reset_enable_bit & !change_enable_bit);
         if (change_enable_bit) begin
            next_s.period_select = {io_wdata[CTL_P3], io_wdata[CTL_PLO+2:CTL_PLO]};
         end
         if (io_wdata[CTL_IF]) begin
            next_s.timeout_irq_flag = 1'b0;
         end
         if (ce_open) begin
            next_s.ce_cnt = CE_CYCLES;
         end
      end
      // Vector execution clears the flag, and the enable in combined mode
      if (vector_ack) begin
         next_s.timeout_irq_flag = 1'b0;
         if (mode == WATCHDOG_CAUSE_FLAG_BOTH) begin
            next_s.timeout_irq_enable = 1'b0;
         end
      end
      // Cause register: writing zero clears, writing one leaves alone
      if (wr_cause) begin
         next_s.watchdog_cause_flag = s.watchdog_cause_flag & io_wdata[CAUSE_WD];
         next_s.brownout_cause_flag = s.brownout_cause_flag & io_wdata[CAUSE_BO];
         next_s.external_cause_flag = s.external_cause_flag & io_wdata[CAUSE_EXT];
         next_s.poweron_cause_flag  = s.poweron_cause_flag & io_wdata[CAUSE_PO];
      end
      // System reset reinitialises the control register
      if (sys_reinit) begin
         next_s.timeout_irq_flag   = CTL_RESET[CTL_IF];
         next_s.timeout_irq_enable = CTL_RESET[CTL_IE];
         next_s.reset_enable_bit   = CTL_RESET[CTL_WDE];
         next_s.period_select      = {CTL_RESET[CTL_P3], CTL_RESET[CTL_PLO+2:CTL_PLO]};
         next_s.ce_cnt             = 3'h0;
      end
      // Hardware sets win over any clear in the same cycle
      if (to_irq) begin
         next_s.timeout_irq_flag = 1'b1;
      end
      if (to_rst) begin
         next_s.watchdog_cause_flag = 1'b1;
      end
      if (bor_reset_event) begin
         next_s.brownout_cause_flag = 1'b1;
      end
      if (ext_reset_event) begin
         next_s.external_cause_flag = 1'b1;
      end
      // Read data answers one cycle after the strobe
      if (io_rd && io_addr == ADDR_WDCTL) begin
         next_s.rdata = ctl_view;
      end else if (io_rd && io_addr == ADDR_CAUSE) begin
         next_s.rdata = cause_view;
      end else if (io_rd) begin
         next_s.rdata = 8'h00;
      end
   end

   // Power-on reset is the only reset that clears the whole block; it marks the cause
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s                    <= '0;
         s.poweron_cause_flag <= POWERON_AT_POR;
      end else begin
         s <= next_s;
      end
   end

   // Counter control; stopped mode holds the counter cleared
   assign cif.run    = (mode != WATCHDOG_CAUSE_FLAG_STOP);
   assign cif.restart = wdr_exec | sys_reinit;
   assign cif.period = s.period_select;

   // Outputs
   assign irq_req         = s.timeout_irq_flag & ie_eff & global_irq_enable;
   assign sys_reset_pulse = s.sys_rst;
   assign io_rdata        = s.rdata;

   property p_fuse_forces;
      @(posedge ref_clk) disable iff (!resetn)
      fuse_prog |-> (mode == WATCHDOG_CAUSE_FLAG_RST) && !irq_req;
   endproperty
   a_fuse_forces: assert property (p_fuse_forces) else $error("fuse did not force reset mode");

   property p_mode_irq;
      @(posedge ref_clk) disable iff (!resetn)
      (cif.timeout && mode == WATCHDOG_CAUSE_FLAG_IRQ) |=> s.timeout_irq_flag && !sys_reset_pulse;
   endproperty
   a_mode_irq: assert property (p_mode_irq) else $error("interrupt mode timeout wrong");

   property p_ce_window;
      @(posedge ref_clk) disable iff (!resetn)
      (ce_open && !sys_reinit) |=> change_enable_bit [*4];
   endproperty
   a_ce_window: assert property (p_ce_window) else $error("change window shorter than four");

   property p_ce_close;
      @(posedge ref_clk) disable iff (!resetn)
      (s.ce_cnt == 3'h1 && !ce_open) |=> !change_enable_bit;
   endproperty
   a_ce_close: assert property (p_ce_close) else $error("change window did not close");

   property p_locked_period;
      @(posedge ref_clk) disable iff (!resetn)
      (wr_ctl && !change_enable_bit && !sys_reinit) |=> $stable(s.period_select);
   endproperty
   a_locked_period: assert property (p_locked_period) else $error("period changed outside window");

   property p_irq_req;
      @(posedge ref_clk) disable iff (!resetn)
      (to_irq && global_irq_enable && !fuse_prog && !wr_ctl && !sys_reinit) |=> irq_req;
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("interrupt not requested");

   property p_vector_clear;
      @(posedge ref_clk) disable iff (!resetn)
      (vector_ack && mode == WATCHDOG_CAUSE_FLAG_BOTH && !to_irq && !wr_ctl) |=> !s.timeout_irq_flag && !s.timeout_irq_enable;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear enable and flag");

   property p_second_timeout;
      @(posedge ref_clk) disable iff (!resetn)
      (cif.timeout && mode == WATCHDOG_CAUSE_FLAG_BOTH && s.timeout_irq_flag) |=> sys_reset_pulse ##1 !sys_reset_pulse;
   endproperty
   a_second_timeout: assert property (p_second_timeout) else $error("no reset on second timeout");

   property p_cause_holds_wde;
      @(posedge ref_clk) disable iff (!resetn)
      s.watchdog_cause_flag |-> ctl_view[CTL_WDE];
   endproperty
   a_cause_holds_wde: assert property (p_cause_holds_wde) else $error("reset enable low with cause flag");

   property p_reset_pulse;
      @(posedge ref_clk) disable iff (!resetn)
      sys_reset_pulse |-> s.watchdog_cause_flag ##1 !sys_reset_pulse;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not one cycle");

endmodule // watchdog_cause_flag_top

// ===== shared/watchdog_cause_flag_cnt_if.sv
`timescale 1ns/1ps
// Carries oscillator ticks and counter control between the watchdog modules
interface watchdog_cause_flag_cnt_if;
   import watchdog_cause_flag_pkg::*;
   logic                tick;
   logic                restart;
   logic                run;
   logic [PER_BITS-1:0] period;
   logic                timeout;

   modport tick_src (output tick);
   modport ctl      (output restart, output run, output period, input timeout);
   modport counter  (input tick, input restart, input run, input period, output timeout);
endinterface

// ===== shared/watchdog_cause_flag_pkg.sv
// Overview of operation
// - Fuse unprogrammed: reset and interrupt enables select mode
// - Programmed fuse forces reset mode, interrupt off
// - Change enable clears itself four cycles later
// - Reset-enable clear, period change need open window
// - Timeout in interrupt modes sets flag bit 7
// - Flag cleared by vector execution or writing one
// - Interrupt requested when flag, enable, global enable set
// - Combined mode vector clears enable and flag
// - Combined mode unserviced second timeout causes reset
// - Watchdog cause flag holds reset enable set
// - Period code selects 2048 to 1048576 oscillator cycles
// - Period bit 3 at bit 5, rest bits 2:0
// - Watchdog, brown-out, external cause flags set, write-zero clear
// - Power-on flag set at power-on, write-zero clear
// - Counter advances on 128 kHz oscillator ticks
// - Restart instruction clears the watchdog counter
// - Reset-mode timeout gives one-cycle reset pulse
package watchdog_cause_flag_pkg;

   // Clock rates and oscillator divider
   localparam int unsigned CLK_HZ   = 250_000_000;
   localparam int unsigned OSC_HZ   = 128_000;
   localparam int unsigned OSC_DIV  = CLK_HZ / OSC_HZ;
   localparam int          DIV_BITS = 16;

   // Register addresses in the data space
   localparam logic [7:0] ADDR_CAUSE = 8'h54;
   localparam logic [7:0] ADDR_WDCTL = 8'h60;

   // Control register field positions
   localparam int CTL_IF  = 7;
   localparam int CTL_IE  = 6;
   localparam int CTL_P3  = 5;
   localparam int CTL_CE  = 4;
   localparam int CTL_WDE = 3;
   localparam int CTL_PLO = 0;

   // Cause register field positions
   localparam int CAUSE_WD  = 3;
   localparam int CAUSE_BO  = 2;
   localparam int CAUSE_EXT = 1;
   localparam int CAUSE_PO  = 0;

   // Values after reset
   localparam logic [7:0] CTL_RESET     = 8'h00;
   localparam logic       POWERON_AT_POR = 1'h1;

   // Change window length in clock cycles
   localparam logic [2:0] CE_CYCLES = 3'h4;

   // Period select
   localparam int         PER_BITS      = 4;
   localparam int         PER_BASE_LOG2 = 11;
   localparam logic [3:0] PER_MAX       = 4'h9;
   localparam int         CNT_BITS      = 20;

   // Operating modes
   typedef enum logic [3:0] {
      WATCHDOG_CAUSE_FLAG_STOP = 4'b0001,
      WATCHDOG_CAUSE_FLAG_IRQ  = 4'b0010,
      WATCHDOG_CAUSE_FLAG_RST  = 4'b0100,
      WATCHDOG_CAUSE_FLAG_BOTH = 4'b1000
   } watchdog_cause_flag_mode_e;

endpackage

// ===== test/watchdog_cause_flag_testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the watchdog with reset-cause flags
module testbench;
   import watchdog_cause_flag_pkg::*;

   // Short tick divider keeps each timeout to a few thousand clocks
   localparam int unsigned div_sim = 2;
   localparam int          per0    = 2048 * div_sim;
   localparam int          ceiling = 60000;

   // Clock, reset and core register port
   logic       ref_clk;
   logic       resetn;
   logic [7:0] io_addr;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   // Core events and reset system
   logic       wdr_exec;
   logic       vector_ack;
   logic       global_irq_enable;
   logic       irq_req;
   logic       always_on_fuse;
   logic       ext_reset_event;
   logic       bor_reset_event;
   logic       sys_reset_pulse;
   // Bench bookkeeping
   logic [7:0] exp_q[$];
   int         n_fail     = 0;
   int         n_compared = 0;
   int         cycles     = 0;
   int         n;
   logic [3:0] p;
   logic [7:0] enc;

   watchdog_cause_flag_top #(.OSC_DIVIDE(div_sim)) dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .wdr_exec(wdr_exec), .vector_ack(vector_ack),
      .global_irq_enable(global_irq_enable), .irq_req(irq_req), .always_on_fuse(always_on_fuse),
      .ext_reset_event(ext_reset_event), .bor_reset_event(bor_reset_event),
      .sys_reset_pulse(sys_reset_pulse)
   );

   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single exit point of the run
   task automatic give_verdict();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One register write, taken at the edge after it is driven
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge ref_clk);
      io_wr <= 1'b0;
   endtask

   // One register read; the expected byte goes to the queue
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      io_addr <= a;
      io_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk);
      io_rd <= 1'b0;
   endtask

   // One-cycle core event: 0 restart, 1 vector, 2 external, 3 brown-out
   task automatic pulse(input int sel);
      @(posedge ref_clk);
      case (sel)
         0: wdr_exec <= 1'b1;
         1: vector_ack <= 1'b1;
         2: ext_reset_event <= 1'b1;
         default: bor_reset_event <= 1'b1;
      endcase
      @(posedge ref_clk);
      wdr_exec        <= 1'b0;
      vector_ack      <= 1'b0;
      ext_reset_event <= 1'b0;
      bor_reset_event <= 1'b0;
   endtask

   // Bounded wait for the interrupt (0) or the reset pulse (1)
   task automatic wait_hi(input int sel, output int cnt);
      cnt = 0;
      do begin
         @(posedge ref_clk);
         #1;
         cnt++;
      end while (((sel == 0) ? irq_req : sys_reset_pulse) !== 1'b1 && cnt < 2 * per0);
   endtask

   // Open the change window, write the setting inside it, then let the window run out
   // so that a following read no longer shows the change enable bit
   task automatic protect(input logic [7:0] d);
      wr(ADDR_WDCTL, 8'h18);
      wr(ADDR_WDCTL, d);
      repeat (2) @(posedge ref_clk);
   endtask

   // Read data is settled one edge after the read is taken and stands until the next read
   initial begin
      forever begin
         @(posedge ref_clk);
         if (io_rd === 1'b1) begin
            @(posedge ref_clk);
            #1;
            check(io_rdata, exp_q.pop_front());
         end
      end
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == ceiling) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      resetn = 1'b0;
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      wdr_exec = 1'b0;
      vector_ack = 1'b0;
      global_irq_enable = 1'b0;
      always_on_fuse = 1'b1;
      ext_reset_event = 1'b0;
      bor_reset_event = 1'b0;
      void'($urandom(68));
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      // Power-on values and an unmapped place
      rd(ADDR_CAUSE, 8'h01);
      rd(ADDR_WDCTL, 8'h00);
      wr(8'h55, 8'($urandom));
      rd(8'h55, 8'h00);
      // Cause flags: events set them, ones written do nothing, zeros clear
      pulse(2);
      rd(ADDR_CAUSE, 8'h03);
      pulse(3);
      rd(ADDR_CAUSE, 8'h07);
      wr(ADDR_CAUSE, 8'hFF);
      rd(ADDR_CAUSE, 8'h07);
      wr(ADDR_CAUSE, 8'h00);
      rd(ADDR_CAUSE, 8'h00);
      // Setting reset enable always takes; clearing or a new period needs the window
      p   = 4'($urandom_range(15, 1));
      enc = {2'b00, p[3], 2'b01, p[2:0]};
      wr(ADDR_WDCTL, 8'h08);
      rd(ADDR_WDCTL, 8'h08);
      wr(ADDR_WDCTL, 8'h00);
      rd(ADDR_WDCTL, 8'h08);
      wr(ADDR_WDCTL, enc);
      rd(ADDR_WDCTL, 8'h08);
      // Window reads open for four cycles, then a late write is ignored
      wr(ADDR_WDCTL, 8'h18);
      rd(ADDR_WDCTL, 8'h18);
      rd(ADDR_WDCTL, 8'h18);
      wr(ADDR_WDCTL, enc & 8'hF7);
      rd(ADDR_WDCTL, 8'h08);
      protect(enc & 8'hF7);
      rd(ADDR_WDCTL, enc & 8'hF7);
      // Interrupt mode on the shortest period
      pulse(0);
      protect(8'h40);
      rd(ADDR_WDCTL, 8'h40);
      global_irq_enable <= 1'b1;
      pulse(0);
      wait_hi(0, n);
      check({7'h0, (n >= per0 - div_sim - 4 && n <= per0 + div_sim + 4)}, 8'h01);
      @(posedge ref_clk);
      global_irq_enable <= 1'b0;
      @(posedge ref_clk);
      #1;
      check({7'h0, irq_req}, 8'h00);
      @(posedge ref_clk);
      global_irq_enable <= 1'b1;
      pulse(1);
      #1;
      check({7'h0, irq_req}, 8'h00);
      // Restart in time keeps the interrupt away
      pulse(0);
      repeat (per0 * 3 / 4) @(posedge ref_clk);
      pulse(0);
      repeat (per0 * 3 / 4) @(posedge ref_clk);
      #1;
      check({7'h0, irq_req}, 8'h00);
      wait_hi(0, n);
      check({7'h0, irq_req}, 8'h01);
      wr(ADDR_WDCTL, 8'hC0);
      rd(ADDR_WDCTL, 8'h40);
      // Combined mode: vector leaves reset mode, unserviced timeout resets
      wr(ADDR_WDCTL, 8'h48);
      wait_hi(0, n);
      check({7'h0, irq_req}, 8'h01);
      pulse(1);
      rd(ADDR_WDCTL, 8'h08);
      wr(ADDR_WDCTL, 8'h48);
      wait_hi(0, n);
      check({7'h0, irq_req}, 8'h01);
      wait_hi(1, n);
      check({7'h0, sys_reset_pulse}, 8'h01);
      @(posedge ref_clk);
      #1;
      check({7'h0, sys_reset_pulse}, 8'h00);
      rd(ADDR_CAUSE, 8'h08);
      rd(ADDR_WDCTL, 8'h08);
      protect(8'h00);
      rd(ADDR_WDCTL, 8'h08);
      wr(ADDR_CAUSE, 8'h00);
      protect(8'h00);
      rd(ADDR_WDCTL, 8'h00);
      // Programmed fuse forces reset mode whatever is written
      always_on_fuse <= 1'b0;
      rd(ADDR_WDCTL, 8'h08);
      wr(ADDR_WDCTL, 8'h40);
      rd(ADDR_WDCTL, 8'h08);
      wait_hi(1, n);
      check({7'h0, sys_reset_pulse}, 8'h01);
      repeat (4) @(posedge ref_clk);
      give_verdict();
   end

endmodule // testbench
